/* File: wdt_pkg.sv */
// Shared constants and types for the bus-attached watchdog
package wdt_pkg;
   localparam int CLK_HZ = 20000000;
   localparam int TICK_HZ = 32768;
   localparam int COUNT_W = 24;

   // I/O addresses watched or served on the bus
   localparam logic [15:0] KEY_PORT = 16'h0302;
   localparam logic [15:0] DATA_PORT = 16'h0303;
   localparam logic [15:0] POSTCODE_PORT = 16'h0080;
   localparam int BASE_ALIGN_W = 3;

   localparam logic [7:0] KEY_ENTER_A = 8'h46;
   localparam logic [7:0] KEY_ENTER_B = 8'h57;
   localparam logic [7:0] KEY_EXIT_A = 8'h57;
   localparam logic [7:0] KEY_EXIT_B = 8'h46;
   localparam logic [7:0] KEY_NONE = 8'h00;

   // Configuration indices
   localparam logic [7:0] IDX_DEV_SEL = 8'h07;
   localparam logic [7:0] IDX_ACT = 8'h30;
   localparam logic [7:0] IDX_CNT0 = 8'h38;
   localparam logic [7:0] IDX_CNT1 = 8'h39;
   localparam logic [7:0] IDX_CNT2 = 8'h3a;
   localparam logic [7:0] IDX_INIT0 = 8'h3b;
   localparam logic [7:0] IDX_INIT1 = 8'h3c;
   localparam logic [7:0] IDX_INIT2 = 8'h3d;
   localparam logic [7:0] IDX_STAT = 8'h3e;
   localparam logic [7:0] IDX_CTRL = 8'h3f;
   localparam logic [7:0] IDX_BASE_HI = 8'h60;
   localparam logic [7:0] IDX_BASE_LO = 8'h61;
   localparam logic [7:0] IDX_IRQ = 8'h70;
   localparam logic [7:0] IDX_KICK = 8'hf1;
   localparam logic [7:0] IDX_W1_LO = 8'hf2;
   localparam logic [7:0] IDX_W1_HI = 8'hf3;
   localparam logic [7:0] IDX_W2_LO = 8'hf4;
   localparam logic [7:0] IDX_W2_HI = 8'hf5;
   localparam logic [7:0] IDX_MASK = 8'hf6;
   localparam logic [7:0] WDT_DEV_NUM = 8'h01;

   // Reset values
   localparam logic [7:0] DEV_SEL_RST = 8'h01;
   localparam logic [7:0] ACT_RST = 8'h01;
   localparam logic [23:0] INIT_RST = 24'h004000;
   localparam logic [7:0] CTRL_RST = 8'h03;
   localparam logic [7:0] MASK_RST = 8'hff;
   localparam logic [7:0] ZERO_RST = 8'h00;

   // Field positions
   localparam int ACT_BIT = 0;
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_RESET_BIT = 1;
   localparam int CTRL_NMI_BIT = 2;
   localparam int STAT_EXP_BIT = 0;
   localparam int KICK_P80_BIT = 4;
   localparam int KICK_W2WR_BIT = 3;
   localparam int KICK_W2RD_BIT = 2;
   localparam int KICK_W1WR_BIT = 1;
   localparam int KICK_W1RD_BIT = 0;
   localparam logic [7:0] KICK_USED = 8'h1f;

   localparam logic [3:0] IRQ_OFF = 4'h0;
   localparam logic [3:0] IRQ_SMI = 4'h2;
   localparam logic [3:0] IRQ_DIS8 = 4'h8;
   localparam logic [3:0] IRQ_DIS_FROM = 4'hd;

   // Bus framing
   localparam logic [3:0] LAD_START = 4'h0;
   localparam logic [3:0] LAD_SYNC_OK = 4'h0;
   localparam logic [3:0] LAD_IDLE = 4'hf;
   localparam logic [1:0] CYC_IO = 2'h0;
   localparam int CYC_DIR_BIT = 1;
   localparam logic [1:0] ADDR_LAST = 2'h3;
   localparam logic [1:0] DATA_LAST = 2'h1;

   typedef enum logic [3:0] {
      ST_IDLE, ST_CYC, ST_ADDR, ST_WDAT, ST_TAR1, ST_TAR2, ST_SYNC, ST_RD0, ST_RD1, ST_TARD
   } lpc_state_e;

   typedef struct packed {
      logic wr;
      logic [15:0] addr;
      logic [7:0] data;
   } lpc_cyc_s;
endpackage

/* File: wdt_tick_gen.sv */
// Fractional divider producing the 32.768 kHz count strobe
`timescale 1ns/1ps
`default_nettype none
module wdt_tick_gen #(
   parameter int CLK_HZ = 20000000,
   parameter int TICK_HZ = 32768
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   output logic tick_o
);
   localparam int ACC_W = $clog2(CLK_HZ) + 1;
   localparam logic [ACC_W-1:0] STEP = ACC_W'(TICK_HZ);
   localparam logic [ACC_W-1:0] WRAP = ACC_W'(CLK_HZ - TICK_HZ);

   logic [ACC_W-1:0] acc_q;
   wire wrap = acc_q >= WRAP;

   // Phase accumulator keeps the average rate exact, jitter is one clock
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_q <= '0;
         tick_o <= 1'b0;
      end else if (ce_i) begin
         tick_o <= wrap;
         acc_q <= wrap ? acc_q - WRAP : acc_q + STEP;
      end
   end
endmodule
`default_nettype wire

/* File: lpc_watchdog_timer.sv */
// Watchdog timer served as an I/O target on the low-pin-count bus
// Notes on behaviour
// - Acts as I/O target on the bus
// - 24-bit count decrements each 32.768 kHz tick
// - Zero count raises interrupt, NMI or reset
// - Timeout equals reload count times tick period
// - Any count byte write reloads from initial
// - Postcode port writes reload when enabled
// - Two address windows reload when enabled
// - Key/index port 302h, data port 303h
// - Keys 46h then 57h enter configuration
// - Keys 57h then 46h leave configuration
// - Index port reads and data port silent outside configuration, key writes still answered
// - Index 7h selects device, resets 01h
// - Index 30h bit 0 enables device
// - Base address at 60h/61h, eight-byte aligned
// - Watchdog registers at 38h-3fh and base+0..7
// - Initial value resets 004000h, control 03h
// - Reload source register F1h resets 00h
// - Window bases at F2h-F5h, low first
// - Window masks at F6h, reset FFh
// - F1h bits select postcode and window kicks
// - Index 70h low nibble picks interrupt line
`timescale 1ns/1ps
`default_nettype none
module lpc_watchdog_timer #(
   parameter int CLK_HZ = wdt_pkg::CLK_HZ,
   parameter int TICK_HZ = wdt_pkg::TICK_HZ
) (
   input wire logic CLOCK_I,
   input wire logic RST_I,
   input wire logic CE_I,
   input wire logic LFRAME_N_I,
   input wire logic [3:0] LAD_I,
   output logic [3:0] LAD_O,
   output logic LAD_OE_O,
   output logic BOARD_RESET_O,
   output logic NMI_O,
   output logic IRQ_O,
   output logic [3:0] IRQ_LINE_O,
   output logic SMI_O
);
   localparam int CW = wdt_pkg::COUNT_W;
   localparam int AW = wdt_pkg::BASE_ALIGN_W;

   function automatic logic win_hit(input logic [15:0] addr, input logic [15:0] base,
                                    input logic [3:0] ignore);
      win_hit = ((addr ^ base) & ~{12'h000, ignore}) == 16'h0000;
   endfunction

   function automatic logic irq_usable(input logic [3:0] sel);
      irq_usable = (sel != wdt_pkg::IRQ_OFF) && (sel != wdt_pkg::IRQ_SMI) &&
                   (sel != wdt_pkg::IRQ_DIS8) && (sel < wdt_pkg::IRQ_DIS_FROM);
   endfunction

   wdt_pkg::lpc_state_e state_q, state_d;
   wdt_pkg::lpc_cyc_s cyc_q;
   logic [1:0] nib_q;
   logic cfg_q;
   logic [7:0] key_prev_q, index_q, dev_sel_q, act_q, stat_q, ctrl_q;
   logic [7:0] irq_sel_q, kick_q, mask_q, rdata_q, rd_mux;
   logic [15:0] base_q, w1_q, w2_q;
   logic [CW-1:0] init_q, count_q, count_d;
   logic [7:0] stat_d;
   logic [3:0] lad_d;
   logic lad_oe_d, tick;

   wdt_tick_gen #(
      .CLK_HZ(CLK_HZ),
      .TICK_HZ(TICK_HZ)
   ) u_tick (
      .clk_i(CLOCK_I),
      .rst_i(RST_I),
      .ce_i(CE_I),
      .tick_o(tick)
   );

   // Address and data are complete in the first turnaround clock
   wire at_tar1 = CE_I && (state_q == wdt_pkg::ST_TAR1);
   wire hit_key = cyc_q.addr == wdt_pkg::KEY_PORT;
   wire hit_data = cyc_q.addr == wdt_pkg::DATA_PORT;
   wire hit_base = act_q[wdt_pkg::ACT_BIT] && (cyc_q.addr[15:AW] == base_q[15:AW]);
   wire via_data = hit_data && cfg_q;
   wire claim = (hit_key && (cyc_q.wr || cfg_q)) || via_data || hit_base;
   wire ld_sel = dev_sel_q == wdt_pkg::WDT_DEV_NUM;
   wire [7:0] io_idx = wdt_pkg::IDX_CNT0 + {5'h00, cyc_q.addr[AW-1:0]};
   wire [7:0] sel_idx = via_data ? index_q : io_idx;
   wire wdt_ok = !via_data || ld_sel;
   wire wr_reg = at_tar1 && cyc_q.wr && (via_data || hit_base);
   wire wr_glob = wr_reg && via_data;
   wire wr_wdt = wr_reg && wdt_ok;
   wire wr_key = at_tar1 && cyc_q.wr && hit_key;
   wire [7:0] wd = cyc_q.data;

   wire key_enter = !cfg_q && key_prev_q == wdt_pkg::KEY_ENTER_A && wd == wdt_pkg::KEY_ENTER_B;
   wire key_exit = cfg_q && key_prev_q == wdt_pkg::KEY_EXIT_A && wd == wdt_pkg::KEY_EXIT_B;

   // Kick sources snoop every I/O cycle, claimed or not
   wire p80_kick = kick_q[wdt_pkg::KICK_P80_BIT] && cyc_q.wr &&
                   cyc_q.addr == wdt_pkg::POSTCODE_PORT;
   wire w1_hit = win_hit(cyc_q.addr, w1_q, mask_q[7:4]);
   wire w2_hit = win_hit(cyc_q.addr, w2_q, mask_q[3:0]);
   wire w1_kick = w1_hit && (cyc_q.wr ? kick_q[wdt_pkg::KICK_W1WR_BIT] :
                                        kick_q[wdt_pkg::KICK_W1RD_BIT]);
   wire w2_kick = w2_hit && (cyc_q.wr ? kick_q[wdt_pkg::KICK_W2WR_BIT] :
                                        kick_q[wdt_pkg::KICK_W2RD_BIT]);
   wire cnt_wr = wr_wdt && (sel_idx == wdt_pkg::IDX_CNT0 || sel_idx == wdt_pkg::IDX_CNT1 ||
                            sel_idx == wdt_pkg::IDX_CNT2);
   wire reload = (at_tar1 && (p80_kick || w1_kick || w2_kick)) || cnt_wr;

   wire active = act_q[wdt_pkg::ACT_BIT] && ctrl_q[wdt_pkg::CTRL_RUN_BIT];
   wire dec = CE_I && tick && active && (count_q != '0);
   wire expire = dec && !reload && (count_q == CW'(1));
   wire stat_clr = wr_wdt && sel_idx == wdt_pkg::IDX_STAT;

   // Reload beats the tick; zero is held rather than wrapped
   assign count_d = reload ? init_q : (dec ? count_q - CW'(1) : count_q);
   // A new expiry wins over a same-cycle write-one-to-clear
   assign stat_d = (stat_q & ~(stat_clr ? wd : 8'h00)) |
                   {7'h00, expire};

   always_comb begin
      unique case (sel_idx)
         wdt_pkg::IDX_ACT: rd_mux = act_q;
         wdt_pkg::IDX_CNT0: rd_mux = count_q[7:0];
         wdt_pkg::IDX_CNT1: rd_mux = count_q[15:8];
         wdt_pkg::IDX_CNT2: rd_mux = count_q[23:16];
         wdt_pkg::IDX_INIT0: rd_mux = init_q[7:0];
         wdt_pkg::IDX_INIT1: rd_mux = init_q[15:8];
         wdt_pkg::IDX_INIT2: rd_mux = init_q[23:16];
         wdt_pkg::IDX_STAT: rd_mux = stat_q;
         wdt_pkg::IDX_CTRL: rd_mux = ctrl_q;
         wdt_pkg::IDX_BASE_HI: rd_mux = base_q[15:8];
         wdt_pkg::IDX_BASE_LO: rd_mux = base_q[7:0];
         wdt_pkg::IDX_IRQ: rd_mux = irq_sel_q;
         wdt_pkg::IDX_KICK: rd_mux = kick_q;
         wdt_pkg::IDX_W1_LO: rd_mux = w1_q[7:0];
         wdt_pkg::IDX_W1_HI: rd_mux = w1_q[15:8];
         wdt_pkg::IDX_W2_LO: rd_mux = w2_q[7:0];
         wdt_pkg::IDX_W2_HI: rd_mux = w2_q[15:8];
         wdt_pkg::IDX_MASK: rd_mux = mask_q;
         default: rd_mux = 8'h00;
      endcase
   end

   wire [7:0] rd_val = hit_key ? index_q :
                       (via_data && sel_idx == wdt_pkg::IDX_DEV_SEL) ? dev_sel_q :
                       wdt_ok ? rd_mux : 8'h00;

   // Cycle framing; a low frame strobe restarts or aborts at any point
   always_comb begin
      state_d = state_q;
      if (!LFRAME_N_I) begin
         state_d = (LAD_I == wdt_pkg::LAD_START) ? wdt_pkg::ST_CYC : wdt_pkg::ST_IDLE;
      end else begin
         unique case (state_q)
            wdt_pkg::ST_IDLE: state_d = wdt_pkg::ST_IDLE;
            wdt_pkg::ST_CYC: state_d = (LAD_I[3:2] == wdt_pkg::CYC_IO) ? wdt_pkg::ST_ADDR : wdt_pkg::ST_IDLE;
            wdt_pkg::ST_ADDR: begin
               if (nib_q == wdt_pkg::ADDR_LAST) begin
                  state_d = cyc_q.wr ? wdt_pkg::ST_WDAT : wdt_pkg::ST_TAR1;
               end
            end
            wdt_pkg::ST_WDAT: begin
               if (nib_q == wdt_pkg::DATA_LAST) begin
                  state_d = wdt_pkg::ST_TAR1;
               end
            end
            wdt_pkg::ST_TAR1: state_d = claim ? wdt_pkg::ST_TAR2 : wdt_pkg::ST_IDLE;
            wdt_pkg::ST_TAR2: state_d = wdt_pkg::ST_SYNC;
            wdt_pkg::ST_SYNC: state_d = cyc_q.wr ? wdt_pkg::ST_TARD : wdt_pkg::ST_RD0;
            wdt_pkg::ST_RD0: state_d = wdt_pkg::ST_RD1;
            wdt_pkg::ST_RD1: state_d = wdt_pkg::ST_TARD;
            wdt_pkg::ST_TARD: state_d = wdt_pkg::ST_IDLE;
            default: state_d = wdt_pkg::ST_IDLE;
         endcase
      end
   end

   // Pin drive is registered from the next state to avoid glitches on the bus
   always_comb begin
      lad_oe_d = 1'b1;
      unique case (state_d)
         wdt_pkg::ST_SYNC: lad_d = wdt_pkg::LAD_SYNC_OK;
         wdt_pkg::ST_RD0: lad_d = rdata_q[3:0];
         wdt_pkg::ST_RD1: lad_d = rdata_q[7:4];
         wdt_pkg::ST_TARD: lad_d = wdt_pkg::LAD_IDLE;
         default: begin
            lad_d = wdt_pkg::LAD_IDLE;
            lad_oe_d = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         state_q <= wdt_pkg::ST_IDLE;
         nib_q <= 2'h0;
         cyc_q <= '0;
         LAD_O <= wdt_pkg::LAD_IDLE;
         LAD_OE_O <= 1'b0;
         rdata_q <= 8'h00;
      end else if (CE_I) begin
         state_q <= state_d;
         LAD_O <= lad_d;
         LAD_OE_O <= lad_oe_d;
         nib_q <= (state_q == wdt_pkg::ST_ADDR || state_q == wdt_pkg::ST_WDAT) &&
                  state_q == state_d ? nib_q + 2'h1 : 2'h0;
         if (state_q == wdt_pkg::ST_CYC) begin
            cyc_q.wr <= LAD_I[wdt_pkg::CYC_DIR_BIT];
         end
         if (state_q == wdt_pkg::ST_ADDR) begin
            cyc_q.addr <= {cyc_q.addr[11:0], LAD_I};
         end
         if (state_q == wdt_pkg::ST_WDAT) begin
            cyc_q.data <= {LAD_I, cyc_q.data[7:4]};
         end
         if (at_tar1 && !cyc_q.wr) begin
            rdata_q <= rd_val;
         end
      end
   end

   // Configuration key sequencer and index port
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         cfg_q <= 1'b0;
         key_prev_q <= wdt_pkg::KEY_NONE;
         index_q <= wdt_pkg::ZERO_RST;
      end else if (CE_I && wr_key) begin
         cfg_q <= key_enter ? 1'b1 : (key_exit ? 1'b0 : cfg_q);
         key_prev_q <= (key_enter || key_exit) ? wdt_pkg::KEY_NONE : wd;
         if (cfg_q) begin
            index_q <= wd;
         end
      end
   end

   // Register file; count bytes are not stored, a write reloads instead
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         dev_sel_q <= wdt_pkg::DEV_SEL_RST;
         act_q <= wdt_pkg::ACT_RST;
         init_q <= wdt_pkg::INIT_RST;
         ctrl_q <= wdt_pkg::CTRL_RST;
         base_q <= '0;
         irq_sel_q <= wdt_pkg::ZERO_RST;
         kick_q <= wdt_pkg::ZERO_RST;
         w1_q <= '0;
         w2_q <= '0;
         mask_q <= wdt_pkg::MASK_RST;
      end else if (CE_I) begin
         if (wr_glob && sel_idx == wdt_pkg::IDX_DEV_SEL) begin
            dev_sel_q <= wd;
         end
         if (wr_wdt) begin
            unique case (sel_idx)
               wdt_pkg::IDX_ACT: act_q <= {7'h00, wd[wdt_pkg::ACT_BIT]};
               wdt_pkg::IDX_INIT0: init_q[7:0] <= wd;
               wdt_pkg::IDX_INIT1: init_q[15:8] <= wd;
               wdt_pkg::IDX_INIT2: init_q[23:16] <= wd;
               wdt_pkg::IDX_CTRL: ctrl_q <= wd;
               wdt_pkg::IDX_BASE_HI: base_q[15:8] <= via_data ? wd : base_q[15:8];
               wdt_pkg::IDX_BASE_LO: base_q[7:0] <= via_data ? {wd[7:AW], 3'h0} : base_q[7:0];
               wdt_pkg::IDX_IRQ: irq_sel_q <= via_data ? {4'h0, wd[3:0]} : irq_sel_q;
               wdt_pkg::IDX_KICK: kick_q <= via_data ? (wd & wdt_pkg::KICK_USED) : kick_q;
               wdt_pkg::IDX_W1_LO: w1_q[7:0] <= via_data ? wd : w1_q[7:0];
               wdt_pkg::IDX_W1_HI: w1_q[15:8] <= via_data ? wd : w1_q[15:8];
               wdt_pkg::IDX_W2_LO: w2_q[7:0] <= via_data ? wd : w2_q[7:0];
               wdt_pkg::IDX_W2_HI: w2_q[15:8] <= via_data ? wd : w2_q[15:8];
               wdt_pkg::IDX_MASK: mask_q <= via_data ? wd : mask_q;
               default: ;
            endcase
         end
      end
   end

   // Count, expiry flag and the selected consequences
   always_ff @(posedge CLOCK_I) begin
      if (RST_I) begin
         count_q <= wdt_pkg::INIT_RST;
         stat_q <= wdt_pkg::ZERO_RST;
         BOARD_RESET_O <= 1'b0;
         NMI_O <= 1'b0;
         IRQ_O <= 1'b0;
         SMI_O <= 1'b0;
         IRQ_LINE_O <= wdt_pkg::IRQ_OFF;
      end else if (CE_I) begin
         count_q <= count_d;
         stat_q <= stat_d;
         BOARD_RESET_O <= expire && ctrl_q[wdt_pkg::CTRL_RESET_BIT];
         NMI_O <= stat_q[wdt_pkg::STAT_EXP_BIT] && ctrl_q[wdt_pkg::CTRL_NMI_BIT];
         IRQ_O <= stat_q[wdt_pkg::STAT_EXP_BIT] && irq_usable(irq_sel_q[3:0]);
         SMI_O <= stat_q[wdt_pkg::STAT_EXP_BIT] && irq_sel_q[3:0] == wdt_pkg::IRQ_SMI;
         IRQ_LINE_O <= irq_sel_q[3:0];
      end
   end

   property p_count_dec;
      @(posedge CLOCK_I) disable iff (RST_I)
      (dec && !reload && count_q > 24'h000001) |=> count_q == $past(count_q) - 24'h000001;
   endproperty
   a_count_dec: assert property (p_count_dec) else $error("count did not step down");

   property p_expire;
      @(posedge CLOCK_I) disable iff (RST_I)
      expire && ctrl_q[wdt_pkg::CTRL_RESET_BIT] |=> stat_q[0] && BOARD_RESET_O && count_q == 24'h000000;
   endproperty
   a_expire: assert property (p_expire) else $error("expiry not signalled");

   property p_hold_zero;
      @(posedge CLOCK_I) disable iff (RST_I)
      (count_q == 24'h000000 && !reload) |=> count_q == 24'h000000;
   endproperty
   a_hold_zero: assert property (p_hold_zero) else $error("count left zero without reload");

   property p_reload;
      @(posedge CLOCK_I) disable iff (RST_I)
      CE_I && reload |=> count_q == $past(init_q);
   endproperty
   a_reload: assert property (p_reload) else $error("reload did not load initial value");

   property p_enter;
      @(posedge CLOCK_I) disable iff (RST_I)
      wr_key && !cfg_q && key_prev_q == 8'h46 && wd == 8'h57 |=> cfg_q;
   endproperty
   a_enter: assert property (p_enter) else $error("key pair did not enter configuration");

   property p_exit;
      @(posedge CLOCK_I) disable iff (RST_I)
      wr_key && cfg_q && key_prev_q == 8'h57 && wd == 8'h46 |=> !cfg_q;
   endproperty
   a_exit: assert property (p_exit) else $error("key pair did not leave configuration");

   property p_silent;
      @(posedge CLOCK_I) disable iff (RST_I)
      at_tar1 && LFRAME_N_I && !cfg_q && !hit_base && (hit_data || (hit_key && !cyc_q.wr))
         |=> state_q == wdt_pkg::ST_IDLE ##1 !LAD_OE_O;
   endproperty
   a_silent: assert property (p_silent) else $error("port answered outside configuration");

   property p_sync;
      @(posedge CLOCK_I) disable iff (RST_I)
      state_q == wdt_pkg::ST_SYNC |-> LAD_OE_O && LAD_O == 4'h0;
   endproperty
   a_sync: assert property (p_sync) else $error("sync nibble not driven");

   property p_align;
      @(posedge CLOCK_I) disable iff (RST_I)
      base_q[2:0] == 3'h0;
   endproperty
   a_align: assert property (p_align) else $error("base address not aligned");
endmodule
`default_nettype wire

/* File: lpc_host_model.sv */
// Host-side bus controller model issuing I/O cycles to the watchdog
`timescale 1ns/1ps
`default_nettype none
module lpc_host_model (
   input wire logic clk_i,
   input wire logic [3:0] lad_i,
   output logic lframe_n_o,
   output logic [3:0] lad_o,
   output logic lad_oe_o,
   output logic rsp_valid_o,
   output logic rsp_claimed_o,
   output logic [7:0] rsp_data_o
);
   initial begin
      lframe_n_o = 1'b1;
      lad_o = 4'hf;
      lad_oe_o = 1'b0;
      rsp_valid_o = 1'b0;
      rsp_claimed_o = 1'b0;
      rsp_data_o = 8'h00;
   end

   // No sync within the wait budget means nobody claimed the cycle
   task automatic run(input logic wr, input logic [15:0] a, input logic [7:0] d);
      logic [3:0] seq [0:7];
      logic got;
      logic [7:0] rd;
      seq = '{4'h0, {2'b00, wr, 1'b0}, a[15:12], a[11:8], a[7:4], a[3:0], d[3:0], d[7:4]};
      got = 1'b0;
      rd = 8'h00;
      for (int i = 0; i < (wr ? 8 : 6); i++) begin
         @(negedge clk_i);
         lframe_n_o <= (i != 0);
         lad_oe_o <= 1'b1;
         lad_o <= seq[i];
      end
      @(negedge clk_i);
      lad_o <= 4'hf;
      // Turnaround: release so only the pull-ups hold the lines
      @(negedge clk_i);
      lad_oe_o <= 1'b0;
      for (int i = 0; i < 6 && !got; i++) begin
         @(posedge clk_i);
         got = (lad_i === 4'h0);
      end
      if (got && !wr) begin
         @(posedge clk_i);
         rd[3:0] = lad_i;
         @(posedge clk_i);
         rd[7:4] = lad_i;
      end
      repeat (2) @(posedge clk_i);
      rsp_claimed_o <= got;
      rsp_data_o <= rd;
      rsp_valid_o <= 1'b1;
      // Valid stands across one rising edge so the watcher samples it
      @(posedge clk_i);
      rsp_valid_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* File: lpc_watchdog_timer_bench.sv */
// Self-checking bench for the bus-attached watchdog
`timescale 1ns/1ps
`default_nettype none
module lpc_watchdog_timer_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   wire logic [3:0] lad_w;
   logic [3:0] dut_lad, h_lad, irq_line;
   logic dut_oe, h_oe, h_frame, board_rst, nmi, irq, smi, rsp_v, rsp_c;
   logic [7:0] rsp_d, r, r2;
   logic [8:0] exp_q[$];
   logic [15:0] base;
   logic [15:0] rtab [14] = '{16'h0701, 16'h3b00, 16'h3c40, 16'h3d00, 16'h3e00, 16'h3f03, 16'h7000,
                              16'hf000, 16'hf100, 16'hf200, 16'hf300, 16'hf400, 16'hf500, 16'hf6ff};
   int num_errors = 0;
   int tests_run = 0;
   int seed = 18804;
   int n;

   always #25 clk = ~clk;
   // Pull-ups hold the nibble when nobody drives
   assign lad_w = dut_oe ? dut_lad : (h_oe ? h_lad : 4'hf);

   // Tick sped to a quarter of the bus clock to keep expiries short
   lpc_watchdog_timer #(.TICK_HZ(wdt_pkg::CLK_HZ / 4)) i_dut (.CLOCK_I(clk), .RST_I(rst), .CE_I(1'b1),
      .LFRAME_N_I(h_frame), .LAD_I(lad_w), .LAD_O(dut_lad), .LAD_OE_O(dut_oe), .BOARD_RESET_O(board_rst),
      .NMI_O(nmi), .IRQ_O(irq), .IRQ_LINE_O(irq_line), .SMI_O(smi));
   lpc_host_model i_host (.clk_i(clk), .lad_i(lad_w), .lframe_n_o(h_frame), .lad_o(h_lad), .lad_oe_o(h_oe),
      .rsp_valid_o(rsp_v), .rsp_claimed_o(rsp_c), .rsp_data_o(rsp_d));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   always @(posedge clk) begin
      if (rsp_v === 1'b1) begin
         if (exp_q.size() == 0) check(16'h1, 16'h0);
         else check({7'h0, rsp_c, rsp_d}, {7'h0, exp_q.pop_front()});
      end
   end

   task automatic close_out;
      $display("counts: %0d compared, %0d mismatched", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   // Expectation is {claimed, read data}
   task automatic io(input logic wr, input logic [15:0] a, input logic [7:0] d, input logic [8:0] e);
      exp_q.push_back(e);
      i_host.run(wr, a, d);
   endtask
   task automatic kw(input logic [7:0] v);
      io(1'b1, wdt_pkg::KEY_PORT, v, 9'h100);
   endtask
   task automatic dr(input logic [8:0] e);
      io(1'b0, wdt_pkg::DATA_PORT, 8'h00, e);
   endtask
   task automatic cw(input logic [7:0] i, input logic [7:0] v);
      kw(i);
      io(1'b1, wdt_pkg::DATA_PORT, v, 9'h100);
   endtask
   task automatic cr(input logic [7:0] i, input logic [7:0] v);
      kw(i);
      dr({1'b1, v});
   endtask
   task automatic bw(input logic [2:0] o, input logic [7:0] v);
      io(1'b1, base + {13'h0, o}, v, 9'h100);
   endtask
   task automatic br(input logic [2:0] o, input logic [7:0] v);
      io(1'b0, base + {13'h0, o}, 8'h00, {1'b1, v});
   endtask
   task automatic wait_hi(input logic pick_rst, input int lim);
      n = 0;
      while ((pick_rst ? board_rst : nmi) !== 1'b1) begin
         @(posedge clk);
         n++;
         if (n > lim) begin
            $display("unexpected at %0t: output never rose", $time);
            num_errors++;
            close_out();
         end
      end
   endtask

   initial begin
      repeat (16) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      dr(9'h000);
      kw(8'h57);
      kw(8'h46);
      dr(9'h000);
      io(1'b0, wdt_pkg::KEY_PORT, 8'h00, 9'h000);
      kw(wdt_pkg::KEY_ENTER_A);
      kw(wdt_pkg::KEY_ENTER_B);
      for (int i = 0; i < 14; i++) cr(rtab[i][15:8], rtab[i][7:0]);
      cw(8'h07, 8'h02);
      cr(8'h3f, 8'h00);
      cw(8'h07, 8'h01);
      done("config");
      cw(8'h60, 8'h02);
      cw(8'h61, 8'h0d);
      cr(8'h61, 8'h08);
      base = 16'h0208;
      r = 8'($random(seed));
      bw(3'd7, 8'h00);
      bw(3'd3, r);
      bw(3'd4, 8'h00);
      bw(3'd5, 8'h00);
      bw(3'd0, 8'($random(seed)));
      br(3'd0, r);
      br(3'd1, 8'h00);
      cr(8'h38, r);
      cw(8'h30, 8'h00);
      io(1'b0, base + 16'h0007, 8'h00, 9'h000);
      cw(8'h30, 8'h01);
      done("base");
      r2 = 8'($random(seed));
      r2[0] = ~r[0];
      bw(3'd3, r2);
      io(1'b1, wdt_pkg::POSTCODE_PORT, r2, 9'h000);
      br(3'd0, r);
      cw(8'hf1, 8'h10);
      io(1'b1, wdt_pkg::POSTCODE_PORT, r2, 9'h000);
      br(3'd0, r2);
      r = r2;
      cw(8'hf3, 8'h04);
      cw(8'hf4, 8'h20);
      cw(8'hf5, 8'h05);
      cw(8'hf6, 8'h3f);
      for (int k = 0; k < 4; k++) begin
         cw(8'hf1, 8'h01 << k);
         r2 = 8'($random(seed));
         r2[0] = ~r[0];
         bw(3'd3, r2);
         io(~k[0], k[1] ? 16'h052f : 16'h0403, r2, 9'h000);
         io(k[0], k[1] ? 16'h0530 : 16'h0404, r2, 9'h000);
         br(3'd0, r);
         io(k[0], k[1] ? 16'h052f : 16'h0403, r2, 9'h000);
         br(3'd0, r2);
         r = r2;
      end
      done("kicks");
      cw(8'hf1, 8'h00);
      bw(3'd3, 8'h20);
      bw(3'd0, 8'h00);
      bw(3'd7, 8'h05);
      wait_hi(1'b0, 300);
      check(16'(n >= 118 && n <= 132), 16'h1);
      br(3'd6, 8'h01);
      for (int c = 0; c < 16; c++) begin
         cw(8'h70, 8'(c));
         check({9'h0, irq_line, nmi, smi, irq}, {9'h0, 4'(c), 1'b1, c == 2, c inside {1, [3:7], [9:12]}});
      end
      for (int i = 0; i < 3; i++) br(3'(i), 8'h00);
      bw(3'd6, 8'h01);
      br(3'd6, 8'h00);
      check({15'h0, nmi}, 16'h0);
      done("expiry");
      bw(3'd7, 8'h03);
      bw(3'd3, 8'h10);
      bw(3'd0, 8'h00);
      wait_hi(1'b1, 200);
      @(posedge clk);
      check({14'h0, board_rst, nmi}, 16'h0);
      kw(wdt_pkg::KEY_EXIT_A);
      kw(wdt_pkg::KEY_EXIT_B);
      dr(9'h000);
      br(3'd7, 8'h03);
      done("exit");
      repeat (4) @(posedge clk);
      close_out();
   end

   initial begin
      repeat (40000) @(posedge clk);
      $display("unexpected at %0t: run limit reached", $time);
      num_errors++;
      close_out();
   end
endmodule
`default_nettype wire
